// ==== bench/esw_chk.sv ====
`timescale 1ns/10ps
// ==============================
// Link checker
module esw_chk #(
   parameter int HALF = esw_pkg::HALF_DEFAULT
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic chip_select_n,
   input wire logic data_cmd,
   input wire logic host_serial_in,
   input wire logic bus_select_strap,
   input wire logic reset_in_n,
   input wire logic busy_out_n
);
   logic       sclk_q;
   logic [3:0] edges;
   logic [3:0] high_run;
   logic [3:0] low_run;

   always_ff @(posedge mclk) begin
      if (rst) begin
         sclk_q   <= 1'b0;
         edges    <= 4'h0;
         high_run <= 4'h0;
         low_run  <= 4'h0;
      end else begin
         sclk_q   <= sclk;
         edges    <= chip_select_n ? 4'h0 : edges + {3'h0, sclk & ~sclk_q};
         high_run <= sclk ? high_run + 4'h1 : 4'h0;
         low_run  <= busy_out_n ? 4'h0 : (low_run == 4'hF ? low_run : low_run + 4'h1);
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   chk_idle_clock_low: assert property (chip_select_n |-> !sclk)
      else $error("serial clock high outside frame");
   chk_data_hold_high: assert property (sclk && $past(sclk) |-> $stable(host_serial_in))
      else $error("serial data moved while clock high");
   chk_dc_tied_low: assert property (bus_select_strap && !chip_select_n |-> !data_cmd)
      else $error("data command pin high in three wire frame");
   chk_strap_frame_hold: assert property (!chip_select_n && !$past(chip_select_n)
      |-> $stable(bus_select_strap))
      else $error("strap changed inside frame");
   chk_dc_frame_hold: assert property (!chip_select_n && !$past(chip_select_n)
      |-> $stable(data_cmd))
      else $error("data command pin changed inside frame");
   chk_frame_bit_count: assert property ($rose(chip_select_n) |->
      edges == (bus_select_strap ? esw_pkg::BITS_3W : esw_pkg::BITS_4W))
      else $error("wrong number of clock edges in frame");
   chk_clock_high_span: assert property ($fell(sclk) |-> high_run == HALF)
      else $error("serial clock high phase wrong length");
   chk_select_after_fall: assert property ($rose(chip_select_n) |-> !$past(sclk))
      else $error("select released with clock high");
   chk_busy_gate_start: assert property ($fell(chip_select_n) |-> low_run < 4'h8)
      else $error("frame started during long busy");

   cover property ($rose(chip_select_n) && bus_select_strap);
   cover property ($rose(chip_select_n) && !bus_select_strap);
   cover property ($fell(busy_out_n) && reset_in_n);
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
   localparam int HALF_TB = 2;
   logic       mclk = 1'b0;
   logic       rst = 1'b1;
   logic       three_wire = 1'b0;
   logic       dev_reset_req = 1'b0;
   logic       cmd_valid = 1'b0;
   logic [7:0] cmd_byte = 8'h00;
   logic       cmd_is_data = 1'b0;
   logic       rx_ready = 1'b0;
   logic [2:0] act = 3'h0;
   logic       cmd_ready, dev_busy, rx_valid, rx_is_data, core_in_reset;
   logic [7:0] rx_byte;
   int         failures = 0;
   int         tests_run = 0;
   bit         ok;

   esw_if link_if ();
   always #12.5 mclk = ~mclk;

   esw_host #(.HALF(HALF_TB)) i_esw_host (.mclk(mclk), .rst(rst), .link(link_if),
      .three_wire(three_wire), .dev_reset_req(dev_reset_req), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_byte(cmd_byte), .cmd_is_data(cmd_is_data),
      .dev_busy(dev_busy));
   esw_device i_esw_device (.mclk(mclk), .rst(rst), .link(link_if), .wave_active(act[0]),
      .otp_active(act[1]), .temp_active(act[2]), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .rx_byte(rx_byte), .rx_is_data(rx_is_data), .core_in_reset(core_in_reset));
   esw_chk #(.HALF(HALF_TB)) i_esw_chk (.mclk(mclk), .rst(rst), .sclk(link_if.sclk),
      .chip_select_n(link_if.chip_select_n), .data_cmd(link_if.data_cmd),
      .host_serial_in(link_if.host_serial_in), .bus_select_strap(link_if.bus_select_strap),
      .reset_in_n(link_if.reset_in_n), .busy_out_n(link_if.busy_out_n));

   // ==============================
   // Access tasks
   task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic send(input logic [7:0] b, input logic d, input int lim, output bit got);
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd_byte <= b;
      cmd_is_data <= d;
      got = 1'b0;
      for (int i = 0; i < lim && !got; i++) begin
         @(negedge mclk);
         got = (cmd_ready === 1'b1);
      end
      @(posedge mclk);
      cmd_valid <= 1'b0;
   endtask

   task automatic recv(input string name, input logic [8:0] exp);
      @(negedge mclk);
      for (int i = 0; i < 400 && rx_valid !== 1'b1; i++)
         @(negedge mclk);
      check(name, {rx_is_data, rx_byte}, exp);
      @(posedge mclk);
      rx_ready <= 1'b1;
      @(posedge mclk);
      rx_ready <= 1'b0;
   endtask

   task automatic set_mode(input logic m);
      @(posedge mclk);
      three_wire <= m;
      send(8'h00, 1'b1, 400, ok);
      @(posedge mclk);
      rx_ready <= 1'b1;
      repeat (150) @(posedge mclk);
      rx_ready <= 1'b0;
   endtask

   task automatic print_verdict();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ==============================
   // Tests
   initial begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      dev_reset_req <= 1'b1;
      repeat (8) @(negedge mclk);
      check("core reset", {8'h00, core_in_reset}, 9'h001);
      @(posedge mclk);
      dev_reset_req <= 1'b0;
      repeat (8) @(negedge mclk);
      check("core run", {8'h00, core_in_reset}, 9'h000);
      $display("test device reset done");
      for (int m = 0; m < 2; m++) begin
         set_mode(m[0]);
         send(8'hA5, 1'b1, 400, ok);
         send(8'h3C, 1'b0, 400, ok);
         recv("rx data", {1'b1, 8'hA5});
         recv("rx command", {1'b0, 8'h3C});
         $display("test framing mode %0d done", m);
      end
      for (int k = 0; k < 3; k++) begin
         @(posedge mclk);
         act <= 3'h1 << k;
         repeat (10) @(negedge mclk);
         check("host busy", {8'h00, dev_busy}, 9'h001);
         send(8'h5A, 1'b1, 60, ok);
         check("busy refused", {8'h00, ok}, 9'h000);
         act <= 3'h0;
         send(8'h5A, 1'b1, 400, ok);
         recv("after busy", {1'b1, 8'h5A});
      end
      $display("test busy sources done");
      for (int i = 0; i < 4; i++)
         send(8'hF0 + 8'(i), 1'b0, 400, ok);
      send(8'hEE, 1'b0, 120, ok);
      check("full refused", {8'h00, ok}, 9'h000);
      for (int i = 0; i < 4; i++)
         recv("fifo order", {1'b0, 8'hF0 + 8'(i)});
      send(8'hEE, 1'b0, 400, ok);
      recv("after drain", 9'h0EE);
      $display("test fifo full done");
      print_verdict();
   end

   initial begin
      repeat (30000) @(posedge mclk);
      failures++;
      print_verdict();
   end
endmodule

// ==== verilog/esw_device.sv ====
`timescale 1ns/10ps

// =====================================================================
// Word FIFO
module esw_fifo #(
   parameter int WIDTH = esw_pkg::FIFO_WIDTH,
   parameter int DEPTH = esw_pkg::FIFO_DEPTH
) (
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("esw_fifo: DEPTH must be a power of two, at least 2");
   end
   if (WIDTH < 1) begin
      $error("esw_fifo: WIDTH must be positive");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0]                 wp;
      logic [AW:0]                 rp;
   } esw_fifo_t;

   esw_fifo_t r;
   esw_fifo_t next_r;
   logic      full;
   logic      empty;

   assign empty     = (r.wp == r.rp);
   assign full      = (r.wp[AW-1:0] == r.rp[AW-1:0]) && (r.wp[AW] != r.rp[AW]);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = r.mem[r.rp[AW-1:0]];

   always_comb begin
      next_r = r;
      if (in_valid && !full) begin
         next_r.mem[r.wp[AW-1:0]] = in_data;
         next_r.wp = r.wp + 1'b1;
      end
      if (out_ready && !empty) begin
         next_r.rp = r.rp + 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
endmodule

// =====================================================================
// Device end
// Function
// - Serial traffic accepted only while select low
// - Four-wire: line high data, low command
// - Strap low selects eight-bit four-wire framing
// - Strap high selects nine-bit three-wire framing
// - Sample on rising clock, MSB first
// - Four-wire: no flag bit, take D/C line, deliver on eighth clock
// - Write only, no read-back path
// - Three-wire: flag then byte, done ninth clock
// - Three-wire flag 1 data, 0 command
// - Host ties unused data/command pin low
// - Busy low during waveform, OTP, sensor work
// - Host waits for busy high before sending
// - Reset input active low
module esw_device #(
   parameter int DEPTH = esw_pkg::FIFO_DEPTH
) (
   input  wire logic       mclk,
   input  wire logic       rst,
   esw_if.dev              link,
   input  wire logic       wave_active,
   input  wire logic       otp_active,
   input  wire logic       temp_active,
   output logic            rx_valid,
   input  wire logic       rx_ready,
   output logic      [7:0] rx_byte,
   output logic            rx_is_data,
   output logic            core_in_reset
);
   // ==================================================================
   // Link domain, clocked by the host serial clock
   typedef struct packed {
      logic [7:0] shift;
      logic       flag;
      logic [7:0] hold;
      logic       hold_dc;
      logic       tog;
      logic       strap_s1;
      logic       strap_s2;
   } esw_link_t;

   esw_link_t  l;
   esw_link_t  next_l;
   logic [3:0] cnt;
   logic [3:0] next_cnt;
   logic [3:0] last_bit;
   logic       frame_done;
   logic [7:0] byte_in;

   assign last_bit   = l.strap_s2 ? esw_pkg::LAST_BIT_3W : esw_pkg::LAST_BIT_4W;
   assign frame_done = (cnt == last_bit);
   assign byte_in    = {l.shift[6:0], link.host_serial_in};

   always_comb begin
      next_l          = l;
      next_cnt        = cnt;
      next_l.strap_s1 = link.bus_select_strap;
      next_l.strap_s2 = l.strap_s1;
      if (!link.chip_select_n) begin
         if (l.strap_s2 && cnt == 4'h0) begin
            next_l.flag = link.host_serial_in;
         end else begin
            next_l.shift = byte_in;
         end
         if (frame_done) begin
            next_cnt       = 4'h0;
            next_l.hold    = byte_in;
            next_l.hold_dc = l.strap_s2 ? l.flag : link.data_cmd;
            next_l.tog     = !l.tog;
         end else begin
            next_cnt = cnt + 4'h1;
         end
      end
   end

   always_ff @(posedge link.sclk or negedge link.reset_in_n) begin
      if (!link.reset_in_n) begin
         l <= '0;
      end else begin
         l <= next_l;
      end
   end

   always_ff @(posedge link.sclk or posedge link.chip_select_n or negedge link.reset_in_n) begin
      if (!link.reset_in_n) begin
         cnt <= 4'h0;
      end else if (link.chip_select_n) begin
         cnt <= 4'h0;
      end else begin
         cnt <= next_cnt;
      end
   end

   // ==================================================================
   // Core domain
   typedef struct packed {
      logic       rst_s1;
      logic       rst_s2;
      logic       tog_s1;
      logic       tog_s2;
      logic       seen;
      logic [1:0] warm;
      logic       busy;
      logic       in_reset;
   } esw_core_t;

   esw_core_t r;
   esw_core_t next_r;
   logic      core_rst;
   logic      push;
   logic      push_ready;
   logic      pop_valid;
   logic [8:0] pop_data;

   assign core_rst = rst || r.in_reset;
   assign push     = (r.warm == esw_pkg::WARM_CYCLES) && (r.tog_s2 != r.seen);

   always_comb begin
      next_r          = r;
      next_r.rst_s1   = link.reset_in_n;
      next_r.rst_s2   = r.rst_s1;
      next_r.in_reset = !r.rst_s2;
      next_r.tog_s1   = l.tog;
      next_r.tog_s2   = r.tog_s1;
      if (r.warm != esw_pkg::WARM_CYCLES || r.in_reset) begin
         next_r.seen = r.tog_s2;
         next_r.warm = (r.warm == esw_pkg::WARM_CYCLES) ? r.warm : r.warm + 2'h1;
      end else if (push && push_ready) begin
         next_r.seen = r.tog_s2;
      end
      next_r.busy = wave_active || otp_active || temp_active || !push_ready || push;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         r <= '{rst_s1: 1'b1, rst_s2: 1'b1, busy: 1'b1, default: '0};
      end else begin
         r <= next_r;
      end
   end

   esw_fifo #(
      .WIDTH (9),
      .DEPTH (DEPTH)
   ) u_fifo (
      .mclk      (mclk),
      .rst       (core_rst),
      .in_valid  (push),
      .in_ready  (push_ready),
      .in_data   ({l.hold_dc, l.hold}),
      .out_valid (pop_valid),
      .out_ready (rx_ready),
      .out_data  (pop_data)
   );

   // No drive back toward the host except busy
   assign link.busy_out_n = !r.busy;
   assign rx_valid        = pop_valid;
   assign rx_byte         = pop_data[7:0];
   assign rx_is_data      = pop_data[8];
   assign core_in_reset   = r.in_reset;
endmodule

// ==== verilog/esw_host.sv ====
`timescale 1ns/10ps

// =====================================================================
// Host end, master of the serial link
module esw_host #(
   parameter int HALF = esw_pkg::HALF_DEFAULT
) (
   input  wire logic       mclk,
   input  wire logic       rst,
   esw_if.host             link,
   input  wire logic       three_wire,
   input  wire logic       dev_reset_req,
   input  wire logic       cmd_valid,
   output logic            cmd_ready,
   input  wire logic [7:0] cmd_byte,
   input  wire logic       cmd_is_data,
   output logic            dev_busy
);
   if (HALF < 1 || HALF > 255) begin
      $error("esw_host: HALF must be 1 to 255");
   end

   localparam logic [7:0] HALF_M1 = 8'(HALF - 1);

   typedef struct packed {
      esw_pkg::esw_hstate_t st;
      logic [7:0]           div;
      logic [3:0]           left;
      logic [8:0]           frame;
      logic                 sclk;
      logic                 cs_n;
      logic                 dc;
      logic                 strap;
      logic                 rst_n;
      logic                 busy_s1;
      logic                 busy_s2;
      logic                 ready;
   } esw_host_t;

   esw_host_t r;
   esw_host_t next_r;
   logic      tick;

   assign tick = (r.div == 8'h00);

   always_comb begin
      next_r         = r;
      next_r.busy_s1 = !link.busy_out_n;
      next_r.busy_s2 = r.busy_s1;
      next_r.rst_n   = !dev_reset_req;
      next_r.div     = tick ? HALF_M1 : r.div - 8'h01;
      next_r.ready   = 1'b0;
      case (r.st)
         esw_pkg::ESW_IDLE: begin
            next_r.strap = three_wire;
            if (cmd_valid && r.ready) begin
               next_r.cs_n = 1'b0;
               next_r.div  = HALF_M1;
               next_r.st   = esw_pkg::ESW_LOW;
               if (r.strap) begin
                  next_r.frame = {cmd_is_data, cmd_byte};
                  next_r.left  = esw_pkg::BITS_3W;
                  next_r.dc    = 1'b0;
               end else begin
                  next_r.frame = {cmd_byte, 1'b0};
                  next_r.left  = esw_pkg::BITS_4W;
                  next_r.dc    = cmd_is_data;
               end
            end else begin
               next_r.ready = !r.busy_s2 && r.rst_n && !r.ready && cmd_valid;
            end
         end
         esw_pkg::ESW_LOW: begin
            if (tick) begin
               next_r.sclk = 1'b1;
               next_r.left = r.left - 4'h1;
               next_r.st   = esw_pkg::ESW_HIGH;
            end
         end
         esw_pkg::ESW_HIGH: begin
            if (tick) begin
               next_r.sclk  = 1'b0;
               next_r.frame = {r.frame[7:0], 1'b0};
               if (r.left == 4'h0) begin
                  next_r.left = esw_pkg::END_GUARD;
                  next_r.st   = esw_pkg::ESW_END;
               end else begin
                  next_r.st   = esw_pkg::ESW_LOW;
               end
            end
         end
         // Guard lets the device's busy reach the host before the next ready
         esw_pkg::ESW_END: begin
            if (r.left == 4'h0) begin
               next_r.cs_n = 1'b1;
               next_r.dc   = 1'b0;
               next_r.st   = esw_pkg::ESW_IDLE;
            end else begin
               next_r.left = r.left - 4'h1;
            end
         end
         default: begin
            next_r.st = esw_pkg::ESW_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         r <= '{st: esw_pkg::ESW_IDLE, cs_n: 1'b1, rst_n: 1'b0, busy_s1: 1'b1,
                busy_s2: 1'b1, default: '0};
      end else begin
         r <= next_r;
      end
   end

   assign link.sclk             = r.sclk;
   assign link.chip_select_n    = r.cs_n;
   assign link.data_cmd         = r.dc;
   assign link.host_serial_in   = r.frame[8];
   assign link.bus_select_strap = r.strap;
   assign link.reset_in_n       = r.rst_n;
   assign cmd_ready             = r.ready;
   assign dev_busy              = r.busy_s2;
endmodule

// ==== verilog/esw_if.sv ====
`timescale 1ns/10ps
interface esw_if;
   logic sclk;
   logic chip_select_n;
   logic data_cmd;
   logic host_serial_in;
   logic bus_select_strap;
   logic reset_in_n;
   logic busy_out_n;

   modport dev (
      input  sclk,
      input  chip_select_n,
      input  data_cmd,
      input  host_serial_in,
      input  bus_select_strap,
      input  reset_in_n,
      output busy_out_n
   );

   modport host (
      output sclk,
      output chip_select_n,
      output data_cmd,
      output host_serial_in,
      output bus_select_strap,
      output reset_in_n,
      input  busy_out_n
   );
endinterface

// ==== verilog/esw_pkg.sv ====
package esw_pkg;

   // =====================================================================
   // Framing
   localparam logic [3:0] LAST_BIT_4W  = 4'h7;
   localparam logic [3:0] LAST_BIT_3W  = 4'h8;
   localparam logic [3:0] BITS_4W      = 4'h8;
   localparam logic [3:0] BITS_3W      = 4'h9;

   // =====================================================================
   // Buffering and timing
   localparam int         FIFO_WIDTH   = 9;
   localparam int         FIFO_DEPTH   = 4;
   localparam logic [1:0] WARM_CYCLES  = 2'h3;
   localparam int         HALF_DEFAULT = 2;
   localparam logic [3:0] END_GUARD    = 4'h3;

   // =====================================================================
   // Host sequencer states
   typedef enum logic [1:0] {
      ESW_IDLE,
      ESW_LOW,
      ESW_HIGH,
      ESW_END
   } esw_hstate_t;

endpackage
